// [design/tsq_sequencer.sv]
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module tsq_sequencer import tsq_pkg::*; #(
  parameter int AW = TSQ_STEP_AW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TSQ_NSRC-1:0] src_in,
  output logic [TSQ_NTRIG-1:0] trig_out,
  output logic irq
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    return a == TSQ_CTRL_OFS || a == TSQ_STAT_OFS || a == TSQ_DELAY_OFS ||
      a == TSQ_ISTAT_OFS || a == TSQ_IMASK_OFS || a == TSQ_WPTR_OFS ||
      a == TSQ_WDATA_OFS;
  endfunction : is_mapped

  function automatic logic is_wait(input logic [3:0] c);
    return c == TSQ_CMD_WHI || c == TSQ_CMD_WLO;
  endfunction : is_wait

  // ----------------------------------------
  // state
  // ----------------------------------------
  tsq_state_t state_r;
  logic [1:0] itm_r;
  logic en_r;
  logic dly_en_r;
  logic [15:0] dly_lim_r;
  logic [15:0] dly_cnt_r;
  logic [TSQ_NIRQ-1:0] istat_r;
  logic [TSQ_NIRQ-1:0] imask_r;
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] ptr_r;
  logic [TSQ_STEP_DW-1:0] step_q;
  logic [TSQ_STEP_DW-1:0] step_r;
  logic [TSQ_NTRIG-1:0] trig_r;
  logic irq_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic wr_acc;
  logic rd_acc;
  logic mem_we;
  logic [3:0] cmd;
  logic [3:0] opt;
  logic hit;
  logic dly_go;
  logic [TSQ_NIRQ-1:0] irq_set;
  tsq_src_if sif ();
  assign wr_acc = psel && penable && pready_r && pwrite;
  assign rd_acc = psel && penable && pready_r && !pwrite;
  assign mem_we = wr_acc && paddr == TSQ_WDATA_OFS;
  assign cmd = step_q[7:4];
  assign opt = step_q[3:0];
  assign sif.sel = step_r[3:0];

  tsq_step_mem #(.AW(AW), .DW(TSQ_STEP_DW)) u_mem (
    .clk(pclk),
    .we(mem_we),
    .waddr(wptr_r),
    .wdata(pwdata[TSQ_STEP_DW-1:0]),
    .raddr(ptr_r),
    .rdata_r(step_q)
  );

  tsq_src_detect u_det (
    .pclk(pclk),
    .presetn(presetn),
    .src_in(src_in),
    .sif(sif)
  );

  // source condition for the held wait step
  always_comb
  begin
    if (itm_r[1])
    begin
      hit = (step_r[7:4] == TSQ_CMD_WHI) ? sif.level : !sif.level;
    end
    else
    begin
      hit = (step_r[7:4] == TSQ_CMD_WHI) ? sif.rise : sif.fall;
    end
  end

  // delay only in the delaying modes and when enabled by a control step
  assign dly_go = !itm_r[0] && dly_en_r && dly_lim_r != 16'h0000;

  always_comb
  begin
    irq_set = '0;
    if (state_r == ST_EXEC && cmd == TSQ_CMD_IRQ && opt <= TSQ_IRQ_LAST)
    begin
      irq_set[opt[1:0]] = 1'b1;
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= psel && !penable;
      pslverr_r <= psel && !penable && !is_mapped(paddr);
      prdata_r <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          TSQ_CTRL_OFS: prdata_r <= {23'h0, dly_en_r, en_r, 5'h0, itm_r};
          TSQ_STAT_OFS: prdata_r <= 32'({ptr_r, 3'(state_r)});
          TSQ_DELAY_OFS: prdata_r <= {16'h0, dly_lim_r};
          TSQ_ISTAT_OFS: prdata_r <= {28'h0, istat_r};
          TSQ_IMASK_OFS: prdata_r <= {28'h0, imask_r};
          TSQ_WPTR_OFS: prdata_r <= 32'(wptr_r);
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      itm_r <= TSQ_ITM_RST;
      en_r <= 1'b0;
      dly_lim_r <= TSQ_DELAY_RST;
      imask_r <= '0;
    end
    else if (wr_acc)
    begin
      case (paddr)
        TSQ_CTRL_OFS:
        begin
          itm_r <= pwdata[TSQ_ITM_LSB +: 2];
          en_r <= pwdata[TSQ_EN_BIT];
        end
        TSQ_DELAY_OFS: dly_lim_r <= pwdata[15:0];
        TSQ_IMASK_OFS: imask_r <= pwdata[TSQ_NIRQ-1:0];
        default: en_r <= en_r;
      endcase
    end
  end

  // step write pointer, auto-increments on each data write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr_r <= '0;
    end
    else if (wr_acc && paddr == TSQ_WPTR_OFS)
    begin
      wptr_r <= pwdata[AW-1:0];
    end
    else if (mem_we)
    begin
      wptr_r <= wptr_r + 1'b1;
    end
  end

  // ----------------------------------------
  // interrupts: sticky, cleared by read, set wins
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      istat_r <= '0;
      irq_r <= 1'b0;
    end
    else
    begin
      if (rd_acc && paddr == TSQ_ISTAT_OFS)
      begin
        istat_r <= (istat_r & ~prdata_r[TSQ_NIRQ-1:0]) | irq_set;
      end
      else
      begin
        istat_r <= istat_r | irq_set;
      end
      irq_r <= |(istat_r & imask_r);
    end
  end

  // ----------------------------------------
  // step engine
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      ptr_r <= '0;
      step_r <= '0;
      dly_en_r <= 1'b0;
      dly_cnt_r <= 16'h0000;
    end
    else if (!en_r)
    begin
      state_r <= ST_IDLE;
      ptr_r <= '0;
    end
    else
    begin
      case (state_r)
        ST_IDLE: state_r <= ST_FETCH;
        ST_FETCH: state_r <= ST_EXEC;
        ST_EXEC:
        begin
          step_r <= step_q;
          ptr_r <= ptr_r + 1'b1;
          dly_cnt_r <= 16'h0000;
          state_r <= is_wait(cmd) ? ST_WAIT : ST_FETCH;
          if (cmd == TSQ_CMD_CTRL && (opt == TSQ_CTRL_DLY_ON || opt == TSQ_CTRL_DLY_OFF))
          begin
            dly_en_r <= (opt == TSQ_CTRL_DLY_ON);
          end
        end
        ST_WAIT:
        begin
          if (hit)
          begin
            state_r <= dly_go ? ST_DELAY : ST_FETCH;
          end
        end
        ST_DELAY:
        begin
          dly_cnt_r <= dly_cnt_r + 16'h0001;
          if (dly_cnt_r == dly_lim_r - 16'h0001)
          begin
            state_r <= ST_FETCH;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // one-cycle trigger pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_r <= '0;
    end
    else if (en_r && state_r == ST_EXEC && cmd[3:1] == TSQ_CMD_TRIG)
    begin
      trig_r <= TSQ_NTRIG'(1) << {cmd[0], opt};
    end
    else
    begin
      trig_r <= '0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign trig_out = trig_r;
  assign irq = irq_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_trig_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    (en_r && state_r == ST_EXEC && cmd[3:1] == TSQ_CMD_TRIG) |=>
    $onehot(trig_out) && trig_out[$past({cmd[0], opt})])
    else $error("trigger output not the selected one");
  a_trig_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_EXEC && cmd[3:1] != TSQ_CMD_TRIG) |=> trig_out == '0)
    else $error("trigger pulse from a non-trigger step");
  a_irq_step: assert property (@(posedge pclk) disable iff (!presetn)
    (en_r && state_r == ST_EXEC && cmd == TSQ_CMD_IRQ && opt <= TSQ_IRQ_LAST) |=>
    istat_r[$past(opt[1:0])] ##1 (irq == (($past(istat_r) & $past(imask_r)) != '0)))
    else $error("interrupt step did not raise its interrupt");
  a_irq_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_EXEC && cmd == TSQ_CMD_IRQ && opt > TSQ_IRQ_LAST &&
    !(rd_acc && paddr == TSQ_ISTAT_OFS)) |=> istat_r == $past(istat_r))
    else $error("reserved interrupt option changed status");
  a_nonwait_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (en_r && state_r == ST_EXEC && !is_wait(cmd)) |=> state_r == ST_FETCH)
    else $error("non-wait step held the sequencer");
  a_wait_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (en_r && state_r == ST_WAIT && !hit) |=> state_r == ST_WAIT)
    else $error("wait step left without its condition");
  a_level_high: assert property (@(posedge pclk) disable iff (!presetn)
    (en_r && state_r == ST_WAIT && itm_r[1] && step_r[7:4] == TSQ_CMD_WHI &&
    src_in[step_r[3:0]]) |=> state_r inside {ST_FETCH, ST_DELAY})
    else $error("level wait missed its selected source");
  a_edge_low: assert property (@(posedge pclk) disable iff (!presetn)
    (en_r && state_r == ST_WAIT && !itm_r[1] && step_r[7:4] == TSQ_CMD_WLO &&
    !src_in[step_r[3:0]] && ($past(src_in) & (TSQ_NSRC'(1) << step_r[3:0])) != '0) |=>
    state_r inside {ST_FETCH, ST_DELAY})
    else $error("edge wait missed its selected source");
  a_skip_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (en_r && state_r == ST_WAIT && hit && itm_r[0]) |=> state_r == ST_FETCH)
    else $error("delay taken in a no-delay mode");
  a_take_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (en_r && state_r == ST_WAIT && hit && !itm_r[0] && dly_en_r &&
    dly_lim_r == 16'h0014) |=> (state_r == ST_DELAY) [*8] ##13 state_r == ST_FETCH)
    else $error("step delay not applied for its length");

  c_trig: cover property (@(posedge pclk) disable iff (!presetn) trig_out != '0);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_delay: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_WAIT ##1 state_r == ST_DELAY);
  c_edge_wait: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_WAIT && !itm_r[1] && hit);
endmodule : tsq_sequencer

// [design/tsq_pkg.sv]
package tsq_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] TSQ_CTRL_OFS = 8'h00;
  localparam logic [7:0] TSQ_STAT_OFS = 8'h04;
  localparam logic [7:0] TSQ_DELAY_OFS = 8'h08;
  localparam logic [7:0] TSQ_ISTAT_OFS = 8'h0C;
  localparam logic [7:0] TSQ_IMASK_OFS = 8'h10;
  localparam logic [7:0] TSQ_WPTR_OFS = 8'h14;
  localparam logic [7:0] TSQ_WDATA_OFS = 8'h18;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int TSQ_ITM_LSB = 0;
  localparam int TSQ_EN_BIT = 7;
  localparam int TSQ_DLYEN_BIT = 8;
  localparam logic [1:0] TSQ_ITM_RST = 2'h0;
  localparam logic [15:0] TSQ_DELAY_RST = 16'h0000;
  localparam int TSQ_NIRQ = 4;
  localparam int TSQ_NSRC = 16;
  localparam int TSQ_NTRIG = 32;
  localparam int TSQ_STEP_AW = 5;
  localparam int TSQ_STEP_DW = 8;
  // ----------------------------------------
  // step command codes (upper nibble) and option codes (lower nibble)
  // ----------------------------------------
  localparam logic [3:0] TSQ_CMD_NOP = 4'h0;
  localparam logic [3:0] TSQ_CMD_CTRL = 4'h1;
  localparam logic [3:0] TSQ_CMD_WHI = 4'h2;
  localparam logic [3:0] TSQ_CMD_WLO = 4'h3;
  localparam logic [3:0] TSQ_CMD_IRQ = 4'h4;
  localparam logic [2:0] TSQ_CMD_TRIG = 3'h4;
  localparam logic [3:0] TSQ_CTRL_DLY_OFF = 4'h0;
  localparam logic [3:0] TSQ_CTRL_DLY_ON = 4'h1;
  localparam logic [3:0] TSQ_IRQ_LAST = 4'h3;
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_WAIT, ST_DELAY} tsq_state_t;
endpackage : tsq_pkg

// [design/tsq_src_if.sv]
`timescale 1ns/1ps
interface tsq_src_if;
  logic [3:0] sel;
  logic level;
  logic rise;
  logic fall;
  modport seq (output sel, input level, input rise, input fall);
  modport det (input sel, output level, output rise, output fall);
endinterface : tsq_src_if

// [design/tsq_step_mem.sv]
`timescale 1ns/1ps
module tsq_step_mem #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_r
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    rdata_r <= mem[raddr];
  end
endmodule : tsq_step_mem

// [design/tsq_src_detect.sv]
`timescale 1ns/1ps
module tsq_src_detect import tsq_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [TSQ_NSRC-1:0] src_in,
  tsq_src_if.det sif
);
  logic [TSQ_NSRC-1:0] prev_r;

  // all sources sampled so a new selection sees no false edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_r <= '0;
    end
    else
    begin
      prev_r <= src_in;
    end
  end

  assign sif.level = src_in[sif.sel];
  assign sif.rise = src_in[sif.sel] & ~prev_r[sif.sel];
  assign sif.fall = ~src_in[sif.sel] & prev_r[sif.sel];
endmodule : tsq_src_detect

// [dv/tsq_src_model.sv]
`timescale 1ns/1ps
module tsq_src_model import tsq_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [TSQ_NSRC-1:0] ev_req,
  output logic [TSQ_NSRC-1:0] src_out
);
  // peripheral event lines, synchronous to pclk, quiet in reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      src_out <= '0;
    else
      src_out <= ev_req;
  end
endmodule : tsq_src_model

// [dv/trigger_sequencer_step_decode_tb_top.sv]
`timescale 1ns/1ps
module trigger_sequencer_step_decode_tb_top import tsq_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] ev_req = 16'h0000;
  logic [15:0] src_in;
  logic [31:0] trig_out;
  logic [31:0] trig_seen = 32'h0;
  logic irq;
  logic clr_seen = 1'b0;
  logic [31:0] rd;
  logic slv;
  logic [15:0] lvl;
  logic [7:0] prog [32];
  logic [7:0] pa [11] = '{8'h80, 8'h9F, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h4F, 8'hF0,
    8'h1A, 8'h50};
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t_hit = 0;
  int t_fire = 0;

  tsq_sequencer i_tsq_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_in(src_in), .trig_out(trig_out), .irq(irq));
  tsq_src_model i_tsq_src_model (.pclk(pclk), .presetn(presetn), .ev_req(ev_req),
    .src_out(src_in));

  initial
  begin
    forever #50 pclk = ~pclk;
  end

  // --------------------------------
  // monitor and timeout
  // --------------------------------
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    trig_seen <= clr_seen ? 32'h0 : (trig_seen | trig_out);
    if (clr_seen)
      t_hit <= 0;
    else if (trig_out[5] === 1'b1 && t_hit == 0)
      t_hit <= cyc;
    if (presetn && !$onehot0(trig_out))
    begin
      err_total++;
      $display("MISMATCH trig_onehot expected onehot seen %h", trig_out);
    end
    if (cyc == 20000)
    begin
      err_total++;
      $display("MISMATCH timeout expected 0 seen 1");
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // --------------------------------
  // bus and program helpers
  // --------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  task automatic load();
    apb(1'b1, TSQ_WPTR_OFS, 32'h0);
    for (int i = 0; i < 32; i++)
      apb(1'b1, TSQ_WDATA_OFS, {24'h0, prog[i]});
    for (int i = 0; i < 32; i++)
      prog[i] = 8'h00;
  endtask : load

  task automatic run(input int m);
    apb(1'b1, TSQ_CTRL_OFS, 32'h80 | 32'(m));
  endtask : run

  task automatic stop_clr();
    apb(1'b1, TSQ_CTRL_OFS, 32'h0);
    @(posedge pclk);
    clr_seen <= 1'b1;
    @(posedge pclk);
    clr_seen <= 1'b0;
  endtask : stop_clr

  // --------------------------------
  // tests
  // --------------------------------
  initial
  begin
    for (int i = 0; i < 32; i++)
      prog[i] = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, TSQ_CTRL_OFS, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, slv});
    apb(1'b1, TSQ_DELAY_OFS, 32'h14);
    apb(1'b0, TSQ_DELAY_OFS, 32'h0);
    chk("delay_reg", 32'h14, rd);
    $display("test registers done");
    for (int k = 0; k < 2; k++)
    begin
      for (int i = 0; i < 11; i++)
        prog[i] = pa[i];
      apb(1'b1, TSQ_IMASK_OFS, 32'h0);
      load();
      run(k * 3);
      idle(40);
      apb(1'b1, TSQ_CTRL_OFS, 32'h0);
      chk("trig_sel", 32'h8000_0001, trig_seen);
      chk("irq_masked", 32'h0, {31'h0, irq});
      apb(1'b1, TSQ_IMASK_OFS, 32'hF);
      idle(2);
      chk("irq_on", 32'h1, {31'h0, irq});
      apb(1'b0, TSQ_ISTAT_OFS, 32'h0);
      chk("istat", 32'hF, rd);
      idle(2);
      chk("irq_off", 32'h0, {31'h0, irq});
      stop_clr();
    end
    $display("test steps done");
    for (int o = 0; o < 16; o++)
    begin
      prog[0] = {o[0] ? TSQ_CMD_WLO : TSQ_CMD_WHI, 4'(o)};
      prog[1] = 8'h80 | 8'(o);
      lvl = 16'h0001 << o;
      ev_req <= o[0] ? lvl : ~lvl;
      load();
      run(3);
      idle(12);
      chk("src_hold", 32'h0, trig_seen);
      apb(1'b0, TSQ_STAT_OFS, 32'h0);
      chk("wait_state", 32'h0B, rd);
      ev_req <= ev_req ^ lvl;
      idle(12);
      chk("src_fire", 32'h1 << o, trig_seen);
      stop_clr();
    end
    $display("test sources done");
    for (int m = 0; m < 4; m++)
    begin
      prog[0] = (m == 3) ? 8'h10 : 8'h11;
      prog[1] = 8'h2E;
      prog[2] = 8'h85;
      ev_req <= 16'h4000;
      load();
      run(m);
      idle(40);
      apb(1'b1, TSQ_CTRL_OFS, 32'h0);
      chk("level_vs_edge", 32'(m[1]), {31'h0, trig_seen[5]});
      stop_clr();
      ev_req <= 16'h0000;
      run(m);
      idle(10);
      apb(1'b0, TSQ_STAT_OFS, 32'h0);
      chk("wait_hold", 32'h13, rd);
      apb(1'b0, TSQ_CTRL_OFS, 32'h0);
      chk("ctrl_delay_en", 32'h80 | 32'(m) | ((m == 3) ? 32'h0 : 32'h100), rd);
      @(posedge pclk);
      ev_req <= 16'h4000;
      t_fire = cyc;
      idle(40);
      chk("trig_after_fire", 32'h1, {31'h0, t_hit != 0});
      chk("delay_applied", m[0] ? 32'h5 : 32'h19, 32'(t_hit - t_fire));
      stop_clr();
    end
    $display("test modes done");
    results();
  end
endmodule : trigger_sequencer_step_decode_tb_top
